// File: rtl/dbev_defs.svh
/*
  constants of the debug event unit: comparator counts, field positions,
  identity layout, exception levels and reset values.
  assumes inclusion by bare name from the package, the watchpoint comparator, the top module and the bench.
*/
// Contract
// - halt opcode enters debug state if permitted
// - exception opcode raises exception, never halts
// - breakpoint address match stops execution
// - watchpoint fires on address or range access
// - halting mode event halts fetch
// - monitor mode event raises debug exception
// - events are synchronous, tied to instruction
// - each event resolves to one action
// - mode follows ext debug status control
// - never both exception and debug entry
// - secure plus untrusted debugger refuses halt
// - bkpt/wpt exception only when debug enabled
// - single step only when exceptions enabled
// - exception opcode always raises exception; the code raises none while in debug state
// - context breakpoints match id or virtual_machine_identifier
// - breakpoints filter by mode, level, security
// - address breakpoint linkable to context breakpoint
// - watchpoints compare load/store addresses, filtered
// - watchpoint access type load, store, both
// - watchpoints never match instruction fetch
// - breakpoint count reported in identity register
// - step exception taken on next instruction
// - debug state: transfer register, no interrupts
`ifndef DBEV_DEFS_SVH
`define DBEV_DEFS_SVH

// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define DBEV_NUM_BP 6
`define DBEV_NUM_WP 4
`define DBEV_AW 64
`define DBEV_CW 32
`define DBEV_VW 16

// ------------------------------------------------------------
// identity register layout
// ------------------------------------------------------------
`define DBEV_ID_BP_LSB 0
`define DBEV_ID_WP_LSB 4
`define DBEV_ID_CTX_LSB 8
`define DBEV_ID_VER_LSB 12
`define DBEV_ID_VERSION 4'h1

// ------------------------------------------------------------
// exception levels and reset values
// ------------------------------------------------------------
`define DBEV_EL0 2'h0
`define DBEV_EL3 2'h3
`define DBEV_ACT_RST 3'h0
`define DBEV_MASK_RST 4'h0

`endif

// File: rtl/dbev_pkg.sv
/*
  types of the debug event unit.
  assumes dbev_defs.svh on the include path.
*/
`include "dbev_defs.svh"
package dbev_pkg;
  typedef enum logic [2:0] {
    DBEV_ACT_NONE,
    DBEV_ACT_EXC,
    DBEV_ACT_HALT,
    DBEV_ACT_PEND,
    DBEV_ACT_IGNORE
  } dbev_act_t;

  typedef enum logic [1:0] {
    DBEV_ACC_NONE,
    DBEV_ACC_LOAD,
    DBEV_ACC_STORE,
    DBEV_ACC_BOTH
  } dbev_acc_t;

  // execution context of the instruction at the comparison point
  typedef struct packed {
    logic [1:0] el;
    logic secure;
    logic [`DBEV_CW-1:0] ctx_id;
    logic [`DBEV_VW-1:0] vm_id;
  } dbev_ctx_t;

  // filter common to breakpoints and watchpoints
  typedef struct packed {
    logic [3:0] el_mask;
    logic match_s;
    logic match_ns;
  } dbev_filt_t;

  typedef struct packed {
    logic en;
    logic is_ctx;
    logic use_virtual_machine_identifier;
    logic linked;
    logic [2:0] link_idx;
    dbev_filt_t filt;
    logic [`DBEV_AW-1:0] addr;
    logic [`DBEV_CW-1:0] ctx_val;
  } dbev_bp_cfg_t;

  typedef struct packed {
    logic en;
    dbev_acc_t acc;
    logic linked;
    logic [2:0] link_idx;
    dbev_filt_t filt;
    logic [`DBEV_AW-1:0] addr;
    logic [5:0] range_lg2;
  } dbev_wp_cfg_t;

  typedef struct packed {
    logic valid;
    logic [`DBEV_AW-1:0] addr;
    logic is_load;
    logic is_store;
    logic is_fetch;
  } dbev_dacc_t;
endpackage

// File: rtl/dbev_wpt.sv
/*
  one data watchpoint comparator, purely combinational.
  assumes the caller supplies the context-breakpoint match vector.
*/
`timescale 1ns/10ps
`include "dbev_defs.svh"
module dbev_wpt (
  input wire dbev_pkg::dbev_wp_cfg_t cfg,
  input wire dbev_pkg::dbev_dacc_t dacc,
  input wire dbev_pkg::dbev_ctx_t ctx,
  input wire logic [`DBEV_NUM_BP-1:0] ctx_hit,
  output logic hit
);
  import dbev_pkg::*;

  logic [`DBEV_AW-1:0] mask;
  logic addr_ok;
  logic acc_ok;
  logic filt_ok;
  logic link_ok;

  always_comb begin
    mask = ~((`DBEV_AW'(1) << cfg.range_lg2) - `DBEV_AW'(1));
    addr_ok = (dacc.addr & mask) == (cfg.addr & mask);
    acc_ok = (dacc.is_load && cfg.acc[0]) || (dacc.is_store && cfg.acc[1]);
    filt_ok = cfg.filt.el_mask[ctx.el] && (ctx.secure ? cfg.filt.match_s : cfg.filt.match_ns);
    link_ok = !cfg.linked || (cfg.link_idx < 3'(`DBEV_NUM_BP) && ctx_hit[cfg.link_idx]);
    // a fetch never qualifies even if a load flag is set alongside it
    hit = cfg.en && dacc.valid && !dacc.is_fetch && addr_ok && acc_ok && filt_ok && link_ok;
  end
endmodule

// File: rtl/dbev_top.sv
/*
  debug event unit: breakpoint and watchpoint comparators, software
  breakpoint opcode decode, single step and the event disposition.
  assumes the pipeline presents the instruction at its check stage
  before commit, with no stall input to hold it, and that
  all control inputs come from logic on MCLK except the debugger
  presence and trust levels, which come from pins.
*/
`timescale 1ns/10ps
`include "dbev_defs.svh"
module dbev_top (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  // configuration
  input wire dbev_pkg::dbev_bp_cfg_t BP_CFG [`DBEV_NUM_BP],
  input wire dbev_pkg::dbev_wp_cfg_t WP_CFG [`DBEV_NUM_WP],
  input wire logic HALT_MODE_SEL,
  input wire logic DBG_EN_NS,
  input wire logic DBG_EN_S,
  input wire logic [3:0] DBG_EL_EN,
  input wire logic [1:0] DBG_TARGET_EL,
  input wire logic STEP_EN,
  input wire logic EXC_MASKED,
  // pins from the debugger
  input wire logic EXT_DBG_ATTACHED,
  input wire logic EXT_DBG_SECURE_OK,
  // pipeline
  input wire logic INSN_VALID,
  input wire logic [`DBEV_AW-1:0] INSN_ADDR,
  input wire logic HALT_OPC,
  input wire logic EXC_OPC,
  input wire logic OTHER_SYNC_EXC,
  input wire dbev_pkg::dbev_ctx_t CTX,
  input wire dbev_pkg::dbev_dacc_t DACC,
  input wire logic RESTART_REQ,
  input wire logic [31:0] ITR_DATA,
  input wire logic ITR_VALID,
  // outputs
  output logic DBG_EXC,
  output logic [1:0] DBG_EXC_EL,
  output logic DBG_HALT_ENTRY,
  output logic IN_DEBUG_STATE,
  output logic FETCH_STOP,
  output logic IRQ_BLOCK,
  output logic INSN_KILL,
  output logic PENDING,
  output logic [`DBEV_NUM_BP-1:0] BP_HIT,
  output logic [`DBEV_NUM_WP-1:0] WP_HIT,
  output logic [31:0] ITR_INSN,
  output logic ITR_INSN_VALID,
  output logic [15:0] ID_REG,
  output dbev_pkg::dbev_act_t LAST_ACT
);
  import dbev_pkg::*;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic att_s1_r;
  logic att_s2_r;
  logic trust_s1_r;
  logic trust_s2_r;

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      att_s1_r <= 1'b0;
      att_s2_r <= 1'b0;
      trust_s1_r <= 1'b0;
      trust_s2_r <= 1'b0;
    end else if (CLK_EN) begin
      att_s1_r <= EXT_DBG_ATTACHED;
      att_s2_r <= att_s1_r;
      trust_s1_r <= EXT_DBG_SECURE_OK;
      trust_s2_r <= trust_s1_r;
    end
  end

  // ----------------------------------------------------------
  // breakpoint comparators
  // ----------------------------------------------------------
  logic [`DBEV_NUM_BP-1:0] ctx_hit;
  logic [`DBEV_NUM_BP-1:0] bp_hit;

  genvar gi;
  generate
    for (gi = 0; gi < `DBEV_NUM_BP; gi++) begin : g_bp
      logic filt_ok;
      logic ctx_ok;
      logic addr_ok;
      logic link_ok;
      always_comb begin
        filt_ok = BP_CFG[gi].filt.el_mask[CTX.el] &&
                  (CTX.secure ? BP_CFG[gi].filt.match_s : BP_CFG[gi].filt.match_ns);
        // virtual_machine_identifier only exists outside secure state
        if (BP_CFG[gi].use_virtual_machine_identifier) begin
          ctx_ok = !CTX.secure && (CTX.vm_id == BP_CFG[gi].ctx_val[`DBEV_VW-1:0]);
        end else begin
          ctx_ok = CTX.ctx_id == BP_CFG[gi].ctx_val;
        end
        addr_ok = INSN_ADDR == BP_CFG[gi].addr;
        // a link index past the last comparator never matches instead of reading x
        link_ok = !BP_CFG[gi].linked ||
                  (BP_CFG[gi].link_idx < 3'(`DBEV_NUM_BP) && ctx_hit[BP_CFG[gi].link_idx]);
      end
      assign ctx_hit[gi] = BP_CFG[gi].en && BP_CFG[gi].is_ctx && filt_ok && ctx_ok;
      assign bp_hit[gi] = INSN_VALID && BP_CFG[gi].en && filt_ok &&
                          (BP_CFG[gi].is_ctx ? ctx_ok : (addr_ok && link_ok));
    end
  endgenerate

  // ----------------------------------------------------------
  // watchpoint comparators
  // ----------------------------------------------------------
  logic [`DBEV_NUM_WP-1:0] wp_hit;

  generate
    for (gi = 0; gi < `DBEV_NUM_WP; gi++) begin : g_wp
      dbev_wpt u_wpt (
        .cfg(WP_CFG[gi]),
        .dacc(DACC),
        .ctx(CTX),
        .ctx_hit(ctx_hit),
        .hit(wp_hit[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------
  // enables and single step
  // ----------------------------------------------------------
  logic dbg_en;
  logic halt_allowed;
  logic step_armed_r;
  logic step_fire;
  logic in_dbg_r;

  assign dbg_en = (CTX.secure ? DBG_EN_S : DBG_EN_NS) && DBG_EL_EN[CTX.el] && !EXC_MASKED;
  // secure code with an untrusted debugger can never be halted
  assign halt_allowed = att_s2_r && (!CTX.secure || trust_s2_r);

  // step arms after one stepped instruction retires, fires on the next
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      step_armed_r <= 1'b0;
    end else if (CLK_EN) begin
      if (!STEP_EN || !dbg_en || step_fire || OTHER_SYNC_EXC) begin
        step_armed_r <= 1'b0;
      end else if (INSN_VALID && !in_dbg_r) begin
        step_armed_r <= 1'b1;
      end
    end
  end
  assign step_fire = step_armed_r && INSN_VALID && dbg_en && !OTHER_SYNC_EXC;

  // ----------------------------------------------------------
  // disposition: one action per instruction, priority ordered
  // ----------------------------------------------------------
  dbev_act_t act_nxt;
  logic any_hw;
  logic pend_r;

  assign any_hw = (|bp_hit) || (|wp_hit);

  always_comb begin
    act_nxt = DBEV_ACT_NONE;
    if (in_dbg_r || !INSN_VALID) begin
      act_nxt = DBEV_ACT_NONE;
    end else if (EXC_OPC) begin
      act_nxt = DBEV_ACT_EXC;
    end else if (HALT_OPC) begin
      act_nxt = halt_allowed ? DBEV_ACT_HALT : DBEV_ACT_IGNORE;
    end else if (pend_r && HALT_MODE_SEL) begin
      // a pend left over from halting mode must not halt once monitor mode is chosen
      act_nxt = halt_allowed ? DBEV_ACT_HALT : DBEV_ACT_PEND;
    end else if (any_hw) begin
      if (HALT_MODE_SEL) begin
        // a halt refused for security is kept until it becomes legal or monitor mode is chosen
        act_nxt = halt_allowed ? DBEV_ACT_HALT : DBEV_ACT_PEND;
      end else begin
        act_nxt = dbg_en ? DBEV_ACT_EXC : DBEV_ACT_IGNORE;
      end
    end else if (step_fire) begin
      act_nxt = DBEV_ACT_EXC;
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      pend_r <= 1'b0;
    end else if (CLK_EN) begin
      if (act_nxt == DBEV_ACT_PEND) begin
        pend_r <= 1'b1;
      end else if (act_nxt == DBEV_ACT_HALT || !HALT_MODE_SEL) begin
        pend_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // action outputs, exc and halt entry exclusive by construction
  // ----------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      DBG_EXC <= 1'b0;
      DBG_EXC_EL <= `DBEV_EL0;
      DBG_HALT_ENTRY <= 1'b0;
      INSN_KILL <= 1'b0;
      LAST_ACT <= DBEV_ACT_NONE;
    end else if (CLK_EN) begin
      DBG_EXC <= act_nxt == DBEV_ACT_EXC;
      DBG_HALT_ENTRY <= act_nxt == DBEV_ACT_HALT;
      if (act_nxt == DBEV_ACT_EXC) begin
        DBG_EXC_EL <= DBG_TARGET_EL;
      end
      // kill stops the hit instruction before it commits
      INSN_KILL <= act_nxt == DBEV_ACT_EXC || act_nxt == DBEV_ACT_HALT;
      if (act_nxt != DBEV_ACT_NONE) begin
        LAST_ACT <= act_nxt;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      BP_HIT <= '0;
      WP_HIT <= '0;
      PENDING <= 1'b0;
    end else if (CLK_EN) begin
      BP_HIT <= bp_hit;
      WP_HIT <= wp_hit;
      PENDING <= pend_r || act_nxt == DBEV_ACT_PEND;
    end
  end

  // ----------------------------------------------------------
  // debug state
  // ----------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      in_dbg_r <= 1'b0;
    end else if (CLK_EN) begin
      if (act_nxt == DBEV_ACT_HALT) begin
        in_dbg_r <= 1'b1;
      end else if (RESTART_REQ) begin
        in_dbg_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      IN_DEBUG_STATE <= 1'b0;
      FETCH_STOP <= 1'b0;
      IRQ_BLOCK <= 1'b0;
    end else if (CLK_EN) begin
      IN_DEBUG_STATE <= act_nxt == DBEV_ACT_HALT || (in_dbg_r && !RESTART_REQ);
      FETCH_STOP <= act_nxt == DBEV_ACT_HALT || (in_dbg_r && !RESTART_REQ);
      IRQ_BLOCK <= act_nxt == DBEV_ACT_HALT || (in_dbg_r && !RESTART_REQ);
    end
  end

  // instructions offered by the debugger only pass while halted
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ITR_INSN <= 32'h0000_0000;
      ITR_INSN_VALID <= 1'b0;
    end else if (CLK_EN) begin
      ITR_INSN_VALID <= in_dbg_r && ITR_VALID && !RESTART_REQ;
      if (in_dbg_r && ITR_VALID) begin
        ITR_INSN <= ITR_DATA;
      end
    end
  end

  // ----------------------------------------------------------
  // identity register
  // ----------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      ID_REG <= 16'h0000;
    end else if (CLK_EN) begin
      ID_REG <= {`DBEV_ID_VERSION, 4'(`DBEV_NUM_BP - 1), 4'(`DBEV_NUM_WP - 1),
                 4'(`DBEV_NUM_BP - 1)};
    end
  end
endmodule

// File: testbench/dbev_sva.sv
/*
  assertions on the debug event unit outputs.
  assumes binding to dbev_top; sees its ports only.
*/
`timescale 1ns/10ps
module dbev_sva (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic CLK_EN,
  input wire logic INSN_VALID,
  input wire logic EXC_OPC,
  input wire logic HALT_OPC,
  input wire logic HALT_MODE_SEL,
  input wire logic RESTART_REQ,
  input wire logic ITR_VALID,
  input wire logic [31:0] ITR_DATA,
  input wire logic DBG_EXC,
  input wire logic DBG_HALT_ENTRY,
  input wire logic INSN_KILL,
  input wire logic IN_DEBUG_STATE,
  input wire logic FETCH_STOP,
  input wire logic IRQ_BLOCK,
  input wire logic ITR_INSN_VALID,
  input wire logic [31:0] ITR_INSN
);
  // ----
  // sequences and checks
  // ----
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);
  sequence exc_take;
    CLK_EN && INSN_VALID && EXC_OPC && !IN_DEBUG_STATE;
  endsequence
  sequence halted;
    IN_DEBUG_STATE && FETCH_STOP && IRQ_BLOCK && CLK_EN;
  endsequence
  opc_exc_a:
    assert property (exc_take |=> DBG_EXC && !DBG_HALT_ENTRY && INSN_KILL) else $error("opcode exc lost");
  one_act_a:
    assert property (!(DBG_EXC && DBG_HALT_ENTRY)) else $error("exc and halt together");
  entry_a:
    assert property ($rose(IN_DEBUG_STATE) |-> DBG_HALT_ENTRY) else $error("halt without entry");
  levels_a:
    assert property (IN_DEBUG_STATE == FETCH_STOP && FETCH_STOP == IRQ_BLOCK) else $error("halt levels differ");
  kill_a:
    assert property (DBG_EXC || DBG_HALT_ENTRY |-> INSN_KILL) else $error("action without kill");
  quiet_a:
    assert property (halted |=> !DBG_EXC && !DBG_HALT_ENTRY) else $error("action while halted");
  restart_a:
    assert property (halted ##0 RESTART_REQ |=> !IN_DEBUG_STATE) else $error("restart ignored");
  stay_a:
    assert property (IN_DEBUG_STATE && !RESTART_REQ |=> IN_DEBUG_STATE) else $error("left halt alone");
  itr_pass_a:
    assert property (halted ##0 (ITR_VALID && !RESTART_REQ) |=> ITR_INSN_VALID && ITR_INSN == $past(ITR_DATA))
      else $error("itr lost");
  mode_sel_a:
    assert property (DBG_HALT_ENTRY |-> $past(HALT_MODE_SEL) || $past(HALT_OPC)) else $error("halt in monitor");
endmodule
bind dbev_top dbev_sva chk (.MCLK, .SRST, .CLK_EN, .INSN_VALID, .EXC_OPC, .HALT_OPC, .HALT_MODE_SEL,
  .RESTART_REQ, .ITR_VALID, .ITR_DATA, .DBG_EXC, .DBG_HALT_ENTRY, .INSN_KILL, .IN_DEBUG_STATE,
  .FETCH_STOP, .IRQ_BLOCK, .ITR_INSN_VALID, .ITR_INSN);

// File: testbench/dbev_dbg_model.sv
/*
  debugger stand-in: presence pins, restart and instruction feed.
  assumes calls from one bench process, off the falling edge.
*/
`timescale 1ns/10ps
module dbev_dbg_model (
  input wire logic mclk,
  output logic attached,
  output logic secure_ok,
  output logic restart_req,
  output logic [31:0] itr_data,
  output logic itr_valid
);
  initial begin
    attached = 1'b0;
    secure_ok = 1'b0;
    restart_req = 1'b0;
    itr_data = 32'h5a5a_5a5a;
    itr_valid = 1'b0;
  end
  task automatic pins(input logic a, t);
    @(negedge mclk);
    attached = a;
    secure_ok = t;
  endtask
  // released data shows its inverse so a stale word never reads right
  task automatic feed(input logic [31:0] v);
    @(negedge mclk);
    itr_data = v;
    itr_valid = 1'b1;
    @(negedge mclk);
    itr_valid = 1'b0;
    itr_data = ~v;
  endtask
  task automatic restart;
    @(negedge mclk);
    restart_req = 1'b1;
    @(negedge mclk);
    restart_req = 1'b0;
  endtask
endmodule

// File: testbench/debug_event_unit_bench.sv
/*
  self-checking bench of the debug event unit.
  assumes dbev_sva is bound and dbev_dbg_model plays the debugger.
*/
`timescale 1ns/10ps
`include "dbev_defs.svh"
module debug_event_unit_bench;
  import dbev_pkg::*;
  localparam logic [63:0] BPA = 64'h0000_0000_0000_8000;
  localparam logic [63:0] WPA = 64'h0000_0000_0001_0000;
  // note: {mask, expected} over {exc, halt, kill, bp hits, wp hits}
  localparam logic [25:0] N_NONE = {13'h1c00, 13'h0000};
  localparam logic [25:0] N_EXC = {13'h1c00, 13'h1400};
  localparam logic [25:0] N_HLT = {13'h1c00, 13'h0c00};
  localparam logic [25:0] N_BPX = {13'h1fff, 13'h1410};
  localparam logic [25:0] N_BPH = {13'h1fff, 13'h0c10};
  localparam logic [25:0] N_WPX = {13'h1fff, 13'h1401};
  logic MCLK = 1'b0, SRST = 1'b1, CLK_EN = 1'b1, OTHER_SYNC_EXC = 1'b0;
  logic INSN_VALID, HALT_OPC, EXC_OPC, HALT_MODE_SEL, DBG_EN_NS, DBG_EN_S, STEP_EN, EXC_MASKED;
  logic [3:0] DBG_EL_EN;
  logic [1:0] DBG_TARGET_EL, DBG_EXC_EL;
  logic [63:0] INSN_ADDR;
  dbev_ctx_t CTX;
  dbev_dacc_t DACC, dv;
  dbev_bp_cfg_t BP_CFG [`DBEV_NUM_BP];
  dbev_wp_cfg_t WP_CFG [`DBEV_NUM_WP];
  logic EXT_DBG_ATTACHED, EXT_DBG_SECURE_OK, RESTART_REQ, ITR_VALID, ITR_INSN_VALID, tk_r;
  logic DBG_EXC, DBG_HALT_ENTRY, IN_DEBUG_STATE, FETCH_STOP, IRQ_BLOCK, INSN_KILL, PENDING;
  logic [5:0] BP_HIT;
  logic [3:0] WP_HIT;
  logic [31:0] ITR_DATA, ITR_INSN;
  logic [15:0] ID_REG;
  dbev_act_t LAST_ACT;
  logic [25:0] q[$];
  logic [25:0] n;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  dbev_top dut (.MCLK, .SRST, .CLK_EN, .BP_CFG, .WP_CFG, .HALT_MODE_SEL, .DBG_EN_NS, .DBG_EN_S,
    .DBG_EL_EN, .DBG_TARGET_EL, .STEP_EN, .EXC_MASKED, .EXT_DBG_ATTACHED, .EXT_DBG_SECURE_OK,
    .INSN_VALID, .INSN_ADDR, .HALT_OPC, .EXC_OPC, .OTHER_SYNC_EXC, .CTX, .DACC, .RESTART_REQ,
    .ITR_DATA, .ITR_VALID, .DBG_EXC, .DBG_EXC_EL, .DBG_HALT_ENTRY, .IN_DEBUG_STATE, .FETCH_STOP,
    .IRQ_BLOCK, .INSN_KILL, .PENDING, .BP_HIT, .WP_HIT, .ITR_INSN, .ITR_INSN_VALID, .ID_REG,
    .LAST_ACT);
  dbev_dbg_model p (.mclk(MCLK), .attached(EXT_DBG_ATTACHED), .secure_ok(EXT_DBG_SECURE_OK),
    .restart_req(RESTART_REQ), .itr_data(ITR_DATA), .itr_valid(ITR_VALID));
  always #10 MCLK = ~MCLK;
  // ----
  // tasks and result watcher
  // ----
  task automatic check(input logic [32:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // held valid between calls so back-to-back issue never double-drives it
  task automatic ins(input logic [63:0] a, input logic h, e, input dbev_dacc_t d, input logic [25:0] nt);
    @(negedge MCLK);
    INSN_ADDR = a;
    HALT_OPC = h;
    EXC_OPC = e;
    DACC = d;
    INSN_VALID = 1'b1;
    q.push_back(nt);
  endtask
  task automatic idle(input int k);
    repeat (k) begin
      @(negedge MCLK);
      INSN_VALID = 1'b0;
    end
  endtask
  task automatic rst;
    @(negedge MCLK);
    SRST = 1'b1;
    repeat (16) @(negedge MCLK);
    SRST = 1'b0;
  endtask
  always @(posedge MCLK) tk_r <= CLK_EN && INSN_VALID && !SRST;
  always @(negedge MCLK) begin
    if (tk_r) begin
      n = q.pop_front();
      check({DBG_EXC, DBG_HALT_ENTRY, INSN_KILL, BP_HIT, WP_HIT} & n[25:13], n[12:0]);
    end
  end
  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      close_out();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'hb42c));
    {INSN_VALID, HALT_OPC, EXC_OPC, HALT_MODE_SEL, STEP_EN, EXC_MASKED} = '0;
    {DBG_EN_NS, DBG_EN_S, DBG_EL_EN, DBG_TARGET_EL} = {2'b11, 4'hf, 2'h2};
    INSN_ADDR = '0;
    DACC = '0;
    CTX = '0;
    CTX.el = 2'h1;
    BP_CFG = '{default: '0};
    WP_CFG = '{default: '0};
    BP_CFG[0] = '{1'b1, 1'b0, 1'b0, 1'b0, 3'h0, '{4'hf, 1'b1, 1'b1}, BPA, 32'h0};
    WP_CFG[0] = '{1'b1, DBEV_ACC_LOAD, 1'b0, 3'h0, '{4'hf, 1'b1, 1'b1}, WPA, 6'h4};
    rst();
    idle(3);
    check(ID_REG, 16'h1535);
    ins(BPA, 0, 0, '0, N_BPX);
    idle(1);
    check(DBG_EXC_EL, 2'h2);
    check(LAST_ACT, DBEV_ACT_EXC);
    EXC_MASKED = 1'b1;
    ins(BPA, 0, 0, '0, N_NONE);
    ins(BPA, 0, 1, '0, N_EXC);
    idle(1);
    EXC_MASKED = 1'b0;
    for (int i = 0; i < 4; i++) begin
      // the fetch also carries a load flag, so only the fetch exclusion keeps it quiet
      dv = '{1'b1, WPA + (i == 3 ? 64'h10 : 64'($urandom % 16)), i != 1, i == 1, i == 2};
      ins(64'h100, 0, 0, dv, i == 0 ? N_WPX : N_NONE);
    end
    idle(1);
    BP_CFG[1] = '{1'b1, 1'b1, 1'b0, 1'b0, 3'h0, '{4'hf, 1'b1, 1'b1}, 64'h0, 32'h0000_0077};
    BP_CFG[2] = '{1'b1, 1'b0, 1'b0, 1'b1, 3'h1, '{4'h2, 1'b1, 1'b1}, 64'h500, 32'h0};
    CTX.ctx_id = 32'h0000_0066;
    ins(64'h500, 0, 0, '0, {13'h1fff, 13'h0000});
    idle(1);
    CTX.ctx_id = 32'h0000_0077;
    ins(64'h500, 0, 0, '0, {13'h1fff, 13'h1460});
    idle(1);
    CTX.el = 2'h2;
    ins(64'h500, 0, 0, '0, {13'h1fff, 13'h1420});
    idle(1);
    CTX.el = 2'h1;
    CTX.secure = 1'b1;
    CTX.vm_id = 16'h0033;
    BP_CFG[1].use_virtual_machine_identifier = 1'b1;
    BP_CFG[1].ctx_val = 32'h0000_0033;
    ins(64'h600, 0, 0, '0, {13'h1fff, 13'h0000});
    idle(1);
    CTX.secure = 1'b0;
    ins(64'h600, 0, 0, '0, {13'h1fff, 13'h1420});
    idle(1);
    BP_CFG[1].en = 1'b0;
    BP_CFG[2].en = 1'b0;
    CTX = '0;
    CTX.el = 2'h1;
    $display("monitor tests done");
    STEP_EN = 1'b1;
    ins(64'h200, 0, 0, '0, N_NONE);
    ins(64'h204, 0, 0, '0, N_EXC);
    idle(1);
    EXC_MASKED = 1'b1;
    ins(64'h208, 0, 0, '0, N_NONE);
    ins(64'h20c, 0, 0, '0, N_NONE);
    idle(1);
    {STEP_EN, EXC_MASKED, HALT_MODE_SEL} = 3'b001;
    rst();
    $display("step tests done");
    p.pins(1'b1, 1'b0);
    idle(3);
    ins(BPA, 0, 0, '0, N_BPH);
    idle(1);
    check(IN_DEBUG_STATE, 1'b1);
    // a restart offered while the clock enable is low is lost with the frozen edge
    CLK_EN = 1'b0;
    p.restart();
    check(IN_DEBUG_STATE, 1'b1);
    CLK_EN = 1'b1;
    ins(BPA, 0, 1, '0, N_NONE);
    idle(1);
    p.feed(32'hc0de_0001);
    check({ITR_INSN_VALID, ITR_INSN}, {1'b1, 32'hc0de_0001});
    p.restart();
    check(IN_DEBUG_STATE, 1'b0);
    ins(64'h300, 1, 0, '0, N_HLT);
    idle(1);
    p.restart();
    CTX.secure = 1'b1;
    ins(64'h300, 1, 0, '0, N_NONE);
    ins(BPA, 0, 0, '0, N_NONE);
    idle(1);
    check(PENDING, 1'b1);
    check(LAST_ACT, DBEV_ACT_PEND);
    p.pins(1'b1, 1'b1);
    idle(3);
    // monitor mode chosen in the very cycle of the next instruction: the pend must not halt
    ins(64'h400, 0, 0, '0, N_NONE);
    HALT_MODE_SEL = 1'b0;
    idle(2);
    check(PENDING, 1'b0);
    HALT_MODE_SEL = 1'b1;
    p.pins(1'b1, 1'b0);
    idle(3);
    ins(BPA, 0, 0, '0, N_NONE);
    idle(1);
    p.pins(1'b1, 1'b1);
    idle(3);
    ins(64'h400, 0, 0, '0, N_HLT);
    idle(1);
    p.restart();
    CTX.secure = 1'b0;
    p.pins(1'b0, 1'b0);
    idle(3);
    ins(64'h300, 1, 0, '0, N_NONE);
    idle(2);
    check(q.size(), 0);
    $display("halting tests done");
    close_out();
  end
endmodule
